// >>> verilog/gauge_pkg.sv
// constants, types and field layout shared by the charge-state gauge block
// Function
// R1: charge state comes from cell voltage and temperature; current is only estimated
// R2: under load, impedance follows predicted open-circuit voltage minus loaded voltage
// R3: full capacity result is deliverable charge at present load down to termination
// R4: uncompensated remaining and full capacity variants are also reported
// R5: initial low-charge flag sets when remaining capacity drops below its threshold
// R6: initial low-charge flag clears when remaining capacity rises above that threshold
// R7: voltage below shutdown set level sets shutdown flag and signals interrupt pin
// R8: set shutdown flag clears above shutdown clear voltage, signalling the pin
// R9: load mode 0 selects constant current (default), 1 selects constant power
// R10: load-mode status bit always mirrors the load-mode setting
// R11: current select 0 uses previous discharge cycle average; every cycle is recorded
// R12: current select 1 (default) uses present cycle running average discharge current
// R13: current select 2 uses average current, 3 a 14 s low-pass current
// R14: current select 4 design capacity/5, 5 at-rate, 6 user rate in mA
// R15: power select 0 previous cycle average power, 1 (default) present average power
// R16: power select 2 average current times voltage, 3 filtered current times voltage
// R17: power select 4 design energy/5, 5 at-rate, 6 user rate, 10 mW units
// R18: reserve charge and energy settings are passed on, compensated at no-load rate
// R19: discharging only when estimated current exceeds discharge threshold
// R20: charging only when estimated current exceeds charge threshold
// R21: host keeps thresholds below normal currents but above noise and drift
// R22: interrupt pin active low with polarity bit clear, else active high
// R23: flags evaluate on each update and hold between updates
package gauge_pkg;
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned PULSE_US      = 1000;
  localparam int unsigned PULSE_CYC_DEF = CLK_HZ / 1_000_000 * PULSE_US;
  localparam int unsigned TAU_S         = 14;
  localparam int unsigned SAMPLE_S      = 1;
  localparam int unsigned LPF_SHIFT     = $clog2(TAU_S / SAMPLE_S);
  localparam int unsigned EFF_SHIFT     = 2;
  localparam int unsigned UW_PER_10MW   = 10000;
  localparam int unsigned HIST_DEPTH    = 8;
  localparam int unsigned HIST_AW       = $clog2(HIST_DEPTH);
  localparam int unsigned NCFG          = 12;

  // byte addresses on the register bus
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] CFG_BASE    = 8'h08;
  localparam logic [7:0] ADDR_LOAD   = 8'h38;
  localparam logic [7:0] ADDR_REM    = 8'h3C;
  localparam logic [7:0] ADDR_FULL   = 8'h40;
  localparam logic [7:0] ADDR_NOM    = 8'h44;
  localparam logic [7:0] ADDR_FAVAIL = 8'h48;
  localparam logic [7:0] ADDR_VOLT   = 8'h4C;
  localparam logic [7:0] ADDR_IRDROP = 8'h50;
  localparam logic [7:0] ADDR_AVG    = 8'h54;

  // configuration word indices, word i at CFG_BASE + 4*i
  localparam int unsigned CFG_INITIAL_LOW_CHARGE_FLAG    = 0;
  localparam int unsigned CFG_SD_SET  = 1;
  localparam int unsigned CFG_SD_CLR  = 2;
  localparam int unsigned CFG_DSG_THR = 3;
  localparam int unsigned CFG_CHG_THR = 4;
  localparam int unsigned CFG_DCAP    = 5;
  localparam int unsigned CFG_DENERGY = 6;
  localparam int unsigned CFG_HYPOTHETICAL_RATE_VALUE  = 7;
  localparam int unsigned CFG_URATE_MA = 8;
  localparam int unsigned CFG_URATE_MW = 9;
  localparam int unsigned CFG_RSV_CHG = 10;
  localparam int unsigned CFG_RSV_EN  = 11;
  localparam logic [NCFG-1:0][15:0] CFG_RST = {16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0172, 16'h03E8, 16'h004B, 16'h003C, 16'h0D48, 16'h0C4E, 16'h0096};

  // control word fields
  localparam int unsigned CTRL_LDMODE = 0;
  localparam int unsigned CTRL_LDSEL  = 1;
  localparam int unsigned CTRL_POL    = 4;
  localparam logic [7:0]  CTRL_RST    = 8'h02;

  // status word fields
  localparam int unsigned ST_LOAD_MODE_STATUS_BIT = 0;
  localparam int unsigned ST_LOW  = 1;
  localparam int unsigned ST_SD   = 2;
  localparam int unsigned ST_DSG  = 3;
  localparam int unsigned ST_CHG  = 4;

  typedef enum logic [2:0] {
    LS_PREV = 3'h0, LS_PRESENT = 3'h1, LS_AVG = 3'h2, LS_LPF = 3'h3,
    LS_DESIGN = 3'h4, LS_HYPOTHETICAL_RATE_VALUE = 3'h5, LS_USER = 3'h6
  } load_sel_t;

  typedef enum logic [1:0] {INT_IDLE = 2'h0, INT_HOLD = 2'h1} int_st_t;

  // one voltage/current sample from the measurement front end
  typedef struct packed {
    logic               stb;
    logic [15:0]        volt_mv;
    logic [15:0]        ocv_mv;
    logic signed [15:0] cur_ma;
    logic [15:0]        temp;
  } meas_t;

  // capacity results from the impedance engine
  typedef struct packed {
    logic        stb;
    logic [15:0] rem;
    logic [15:0] full;
    logic [15:0] nom;
    logic [15:0] favail;
  } results_t;

  // settings handed back to the impedance engine
  typedef struct packed {
    logic        load_mode;
    logic [15:0] load_value;
    logic [15:0] rsv_chg;
    logic [15:0] rsv_en;
    logic        dsg;
    logic        chg;
  } engine_t;
endpackage

// >>> verilog/cycle_hist_mem.sv
// record of average discharge current and power, one word per discharge cycle
`timescale 1ns/1ps
`default_nettype none
module cycle_hist_mem
  import gauge_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               ce,
  input  wire logic               we,
  input  wire logic [HIST_AW-1:0] waddr,
  input  wire logic [31:0]        wdata,
  input  wire logic [HIST_AW-1:0] raddr,
  output logic      [31:0]        rdata
);
  typedef struct packed {
    logic [HIST_DEPTH-1:0][31:0] mem;
    logic [31:0]                 rd;
  } mem_st_t;

  mem_st_t m_q;
  mem_st_t m_d;

  assign rdata = m_q.rd;

  // read data always registered; content has no reset, a fresh record is unused
  always_comb
  begin
    m_d = m_q;
    m_d.rd = m_q.mem[raddr];
    if (we)
    begin
      m_d.mem[waddr] = wdata;
    end
  end

  // frozen while the clock enable is low
  always_ff @(posedge sys_clk)
  begin
    if (ce)
    begin
      m_q <= m_d;
    end
  end
endmodule
`default_nettype wire

// >>> verilog/charge_state_gauge.sv
// charge-state flags, load model selection and register slave of the gauge
`timescale 1ns/1ps
`default_nettype none
module charge_state_gauge #(
  parameter logic [15:0] PULSE_CYC = 16'(gauge_pkg::PULSE_CYC_DEF)
) (
  input  wire logic                sys_clk,
  input  wire logic                rst,
  input  wire logic                ce,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  input  wire gauge_pkg::meas_t    meas_i,
  input  wire gauge_pkg::results_t res_i,
  output logic                     soc_int_o,
  output gauge_pkg::engine_t       eng_o
);
  import gauge_pkg::*;

  typedef struct packed {
    logic [7:0]            ctrl;
    logic [NCFG-1:0][15:0] cfg;
    logic                  low_flag;
    logic                  sd_flag;
    logic                  dsg;
    logic                  chg;
    logic [15:0]           volt;
    logic [15:0]           temp;
    logic [15:0]           ir_drop;
    logic [15:0]           rem;
    logic [15:0]           full;
    logic [15:0]           nom;
    logic [15:0]           favail;
    logic [15:0]           avg_i;
    logic [15:0]           avg_p;
    logic [15:0]           eff_avg;
    logic [15:0]           lpf;
    logic [7:0]            nsamp;
    logic [HIST_AW-1:0]    wptr;
    logic                  hist_we;
    int_st_t               ist;
    logic [15:0]           pcnt;
    logic                  pin;
    logic                  ack;
    logic [31:0]           dat;
    logic [15:0]           load_val;
  } state_t;

  state_t      s_q;
  state_t      s_d;
  logic [31:0] prev_rec;
  logic [15:0] mag;
  logic [15:0] pw;
  logic        trig;
  logic        pol;
  logic [7:0]  a;

  // true when the byte address falls on a configuration word
  function automatic logic cfg_hit(input logic [7:0] ad);
    return (ad >= CFG_BASE) && (ad < 8'(CFG_BASE + NCFG * 4));
  endfunction

  function automatic logic [3:0] cfg_idx(input logic [7:0] ad);
    return 4'((ad - CFG_BASE) >> 2);
  endfunction

  // power in 10 mW units from mA and mV
  function automatic logic [15:0] pwr(input logic [15:0] i, input logic [15:0] v);
    logic [31:0] pr;
    pr = 32'(i) * 32'(v);
    pr = pr / 32'(UW_PER_10MW);
    return pr[15:0];
  endfunction

  // first-order step toward x, weight 2^-k; no divider needed
  function automatic logic [15:0] avg_step(input logic [15:0] av, input logic [15:0] x,
                                          input logic [2:0] k);
    logic signed [16:0] df;
    df = signed'({1'b0, x}) - signed'({1'b0, av});
    return av + 16'(df >>> k);
  endfunction

  // step weight shrinks as the sample count grows so early samples count fully
  function automatic logic [2:0] log2n(input logic [7:0] n);
    logic [2:0] k;
    k = 3'h0;
    for (int b = 1; b < 8; b++)
    begin
      if (n >= 8'(1 << b))
      begin
        k = 3'(b);
      end
    end
    return k;
  endfunction

  // register read mux
  function automatic logic [31:0] rd_mux(input logic [7:0] ad, input state_t s);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (cfg_hit(ad))
    begin
      r = {16'h0000, s.cfg[cfg_idx(ad)]};
    end
    case (ad)
      ADDR_CTRL:   r = {24'h00_0000, s.ctrl};
      // R10: status mirrors load mode
      ADDR_STATUS: r = {27'h000_0000, s.chg, s.dsg, s.sd_flag, s.low_flag,
                        s.ctrl[CTRL_LDMODE]};
      ADDR_LOAD:   r = {16'h0000, s.load_val};
      ADDR_REM:    r = {16'h0000, s.rem};
      ADDR_FULL:   r = {16'h0000, s.full};
      ADDR_NOM:    r = {16'h0000, s.nom};
      ADDR_FAVAIL: r = {16'h0000, s.favail};
      ADDR_VOLT:   r = {s.temp, s.volt};
      ADDR_IRDROP: r = {16'h0000, s.ir_drop};
      ADDR_AVG:    r = {s.avg_p, s.avg_i};
      default:     r = r;
    endcase
    return r;
  endfunction

  assign a   = {wb_adr_i[7:2], 2'b00};
  assign pol = s_q.ctrl[CTRL_POL];

  // every output is a field of the registered state
  assign wb_dat_o  = s_q.dat;
  assign wb_ack_o  = s_q.ack;
  assign soc_int_o = s_q.pin;
  // R18: reserves passed through
  assign eng_o = '{load_mode: s_q.ctrl[CTRL_LDMODE], load_value: s_q.load_val,
                   rsv_chg: s_q.cfg[CFG_RSV_CHG], rsv_en: s_q.cfg[CFG_RSV_EN],
                   dsg: s_q.dsg, chg: s_q.chg};

  // previous cycle record sits one slot behind the write pointer
  cycle_hist_mem u_hist (
    .sys_clk (sys_clk),
    .ce      (ce),
    .we      (s_q.hist_we),
    .waddr   (s_q.wptr),
    .wdata   ({s_q.avg_p, s_q.avg_i}),
    .raddr   (s_q.wptr - HIST_AW'(1)),
    .rdata   (prev_rec)
  );

  // discharge magnitude and power of the incoming sample
  assign mag = (meas_i.cur_ma < 0) ? 16'(-meas_i.cur_ma) : 16'h0000;
  assign pw  = pwr(mag, meas_i.volt_mv);

  always_comb
  begin
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.hist_we = 1'b0;
    trig = 1'b0;

    // classic wishbone: answer one cycle after the request, unmapped reads give zero
    if (wb_cyc_i && wb_stb_i && !s_q.ack)
    begin
      s_d.ack = 1'b1;
      s_d.dat = rd_mux(a, s_q);
      if (wb_we_i && a == ADDR_CTRL && wb_sel_i[0])
      begin
        s_d.ctrl = {3'b000, wb_dat_i[4:0]};
      end
      if (wb_we_i && cfg_hit(a))
      begin
        for (int b = 0; b < 2; b++)
        begin
          if (wb_sel_i[b])
          begin
            s_d.cfg[cfg_idx(a)][8*b +: 8] = wb_dat_i[8*b +: 8];
          end
        end
      end
    end

    // R1: a new voltage and temperature sample drives the estimate
    if (meas_i.stb)
    begin
      s_d.volt = meas_i.volt_mv;
      s_d.temp = meas_i.temp;
      // R19: discharge needs the threshold exceeded
      s_d.dsg = mag > s_q.cfg[CFG_DSG_THR];
      // R20: charge needs the threshold exceeded
      s_d.chg = meas_i.cur_ma > 0 && 16'(meas_i.cur_ma) > s_q.cfg[CFG_CHG_THR];
      // R2: loaded drop from predicted open-circuit voltage
      s_d.ir_drop = (s_d.dsg && meas_i.ocv_mv > meas_i.volt_mv) ?
                    meas_i.ocv_mv - meas_i.volt_mv : 16'h0000;
      // R13: average and 14 s filtered current
      s_d.eff_avg = avg_step(s_q.eff_avg, mag, 3'(EFF_SHIFT));
      s_d.lpf = avg_step(s_q.lpf, mag, 3'(LPF_SHIFT));
      // R12: running averages restart at each discharge start
      if (s_d.dsg && !s_q.dsg)
      begin
        s_d.avg_i = mag;
        s_d.avg_p = pw;
        s_d.nsamp = 8'h01;
      end
      else if (s_d.dsg)
      begin
        s_d.nsamp = (s_q.nsamp == 8'hFF) ? s_q.nsamp : s_q.nsamp + 8'h01;
        s_d.avg_i = avg_step(s_q.avg_i, mag, log2n(s_d.nsamp));
        s_d.avg_p = avg_step(s_q.avg_p, pw, log2n(s_d.nsamp));
      end
      // R11: each finished discharge cycle is recorded
      if (s_q.dsg && !s_d.dsg)
      begin
        s_d.hist_we = 1'b1;
      end
      // R7: undervoltage sets shutdown flag, pin signals
      if (meas_i.volt_mv < s_q.cfg[CFG_SD_SET])
      begin
        trig = !s_q.sd_flag;
        s_d.sd_flag = 1'b1;
      end
      // R8: clears only above separate clear level
      else if (s_q.sd_flag && meas_i.volt_mv > s_q.cfg[CFG_SD_CLR])
      begin
        trig = 1'b1;
        s_d.sd_flag = 1'b0;
      end
    end
    if (s_q.hist_we)
    begin
      s_d.wptr = s_q.wptr + HIST_AW'(1);
    end

    // R4: compensated and uncompensated results captured together
    if (res_i.stb)
    begin
      s_d.rem = res_i.rem;
      // R3: full capacity is that at present load
      s_d.full = res_i.full;
      s_d.nom = res_i.nom;
      s_d.favail = res_i.favail;
      // R5: set below threshold
      if (res_i.rem < s_q.cfg[CFG_INITIAL_LOW_CHARGE_FLAG])
      begin
        s_d.low_flag = 1'b1;
      end
      // R6: clear above threshold; R23: equal holds state
      else if (res_i.rem > s_q.cfg[CFG_INITIAL_LOW_CHARGE_FLAG])
      begin
        s_d.low_flag = 1'b0;
      end
    end

    // pulse timer; a new event during a pulse restarts it so none is lost
    case (s_q.ist)
      INT_IDLE:
      begin
        s_d.pcnt = 16'h0000;
      end
      INT_HOLD:
      begin
        s_d.pcnt = s_q.pcnt - 16'h0001;
        if (s_q.pcnt == 16'h0000)
        begin
          s_d.ist = INT_IDLE;
        end
      end
      default:
      begin
        s_d.ist = INT_IDLE;
      end
    endcase
    if (trig)
    begin
      s_d.ist = INT_HOLD;
      s_d.pcnt = PULSE_CYC - 16'h0001;
    end
    // R22: polarity chooses the active level
    s_d.pin = (s_d.ist == INT_HOLD) ? s_d.ctrl[CTRL_POL] : !s_d.ctrl[CTRL_POL];

    // R9: mode bit picks current or power table
    if (!s_q.ctrl[CTRL_LDMODE])
    begin
      // R14: current-model options
      case (load_sel_t'(s_q.ctrl[CTRL_LDSEL +: 3]))
        LS_PREV:    s_d.load_val = prev_rec[15:0];
        LS_PRESENT: s_d.load_val = s_q.avg_i;
        LS_AVG:     s_d.load_val = s_q.eff_avg;
        LS_LPF:     s_d.load_val = s_q.lpf;
        LS_DESIGN:  s_d.load_val = s_q.cfg[CFG_DCAP] / 16'h0005;
        LS_HYPOTHETICAL_RATE_VALUE:  s_d.load_val = s_q.cfg[CFG_HYPOTHETICAL_RATE_VALUE];
        LS_USER:    s_d.load_val = s_q.cfg[CFG_URATE_MA];
        default:    s_d.load_val = s_q.avg_i;
      endcase
    end
    else
    begin
      // R15: power-model options; R16 and R17 products and rates
      case (load_sel_t'(s_q.ctrl[CTRL_LDSEL +: 3]))
        LS_PREV:    s_d.load_val = prev_rec[31:16];
        LS_PRESENT: s_d.load_val = s_q.avg_p;
        LS_AVG:     s_d.load_val = pwr(s_q.eff_avg, s_q.volt);
        LS_LPF:     s_d.load_val = pwr(s_q.lpf, s_q.volt);
        LS_DESIGN:  s_d.load_val = s_q.cfg[CFG_DENERGY] / 16'h0005;
        LS_HYPOTHETICAL_RATE_VALUE:  s_d.load_val = s_q.cfg[CFG_HYPOTHETICAL_RATE_VALUE];
        LS_USER:    s_d.load_val = s_q.cfg[CFG_URATE_MW];
        default:    s_d.load_val = s_q.avg_p;
      endcase
    end
  end

  // synchronous reset; clock enable freezes every field
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_q      <= '0;
      s_q.ctrl <= CTRL_RST;
      s_q.cfg  <= CFG_RST;
      s_q.pin  <= !CTRL_RST[CTRL_POL];
    end
    else if (ce)
    begin
      s_q <= s_d;
    end
  end

  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_LOW_SET: assert property (ce && res_i.stb && res_i.rem < s_q.cfg[CFG_INITIAL_LOW_CHARGE_FLAG] // R5
    |=> s_q.low_flag) else $error("low flag not set");
  AST_LOW_CLR: assert property (ce && res_i.stb && res_i.rem > s_q.cfg[CFG_INITIAL_LOW_CHARGE_FLAG] // R6
    |=> !s_q.low_flag) else $error("low flag not cleared");
  AST_SD_SET: assert property (ce && meas_i.stb && !s_q.sd_flag // R7
    && meas_i.volt_mv < s_q.cfg[CFG_SD_SET] |=> s_q.sd_flag && soc_int_o == pol)
    else $error("shutdown set without pulse");
  AST_SD_CLR: assert property (ce && meas_i.stb && s_q.sd_flag // R8
    && meas_i.volt_mv >= s_q.cfg[CFG_SD_SET] && meas_i.volt_mv > s_q.cfg[CFG_SD_CLR]
    |=> !s_q.sd_flag && s_q.ist == INT_HOLD) else $error("shutdown clear wrong");
  AST_LOAD_MODE_STATUS_BIT: assert property (ce && wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i // R10
    && a == ADDR_STATUS |=> wb_ack_o && wb_dat_o[ST_LOAD_MODE_STATUS_BIT] == s_q.ctrl[CTRL_LDMODE])
    else $error("mode status mismatch");
  AST_NO_DSG: assert property (ce && meas_i.stb && meas_i.cur_ma >= 0 // R19
    |=> !s_q.dsg) else $error("discharge without current");
  AST_NO_CHG: assert property (ce && meas_i.stb // R20
    && meas_i.cur_ma <= signed'(s_q.cfg[CFG_CHG_THR]) |=> !s_q.chg)
    else $error("charge below threshold");
  AST_IDLE_PIN: assert property (s_q.ist == INT_IDLE |-> soc_int_o != pol) // R22
    else $error("pin active while idle");
  AST_CC_DESIGN: assert property (ce && !s_q.ctrl[CTRL_LDMODE] // R14
    && s_q.ctrl[CTRL_LDSEL +: 3] == 3'h4
    |=> s_q.load_val == $past(s_q.cfg[CFG_DCAP]) / 16'h0005)
    else $error("design rate wrong");
  AST_ACK_ONE: assert property (wb_ack_o && ce |=> !wb_ack_o)
    else $error("ack held two cycles");
endmodule
`default_nettype wire

// >>> verif/wb_host_model.sv
// system microcontroller model: classic wishbone master issuing single cycles
`timescale 1ns/1ps
`default_nettype none
module wb_host_model (
  input  wire logic        sys_clk,
  input  wire logic        ack,
  input  wire logic [31:0] rdat,
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic [7:0]       adr,
  output logic [3:0]       sel,
  output logic [31:0]      wdat
);
  // idle bus at time zero
  initial
  begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
  end

  // one transfer; released address and write data show inverted values so stale data cannot pass
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= wd;
    do @(posedge sys_clk); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    adr <= ~a;
    wdat <= ~wd;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    xfer(1'b1, a, d, unused);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    xfer(1'b0, a, 32'h0, d);
  endtask
endmodule
`default_nettype wire

// >>> verif/charge_state_flags_and_load_model_tb_top.sv
// self-checking bench for the charge-state flags and load model block
`timescale 1ns/1ps
`default_nettype none
module charge_state_flags_and_load_model_tb_top
  import gauge_pkg::*;
;
  localparam logic [15:0] PULSE = 16'h0008;
  localparam int LIMIT = 5000;
  typedef struct packed {
    logic [15:0] volt;
    logic signed [15:0] cur;
    logic [15:0] rem;
    logic [4:0] st;
  } row_t;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [15:0] val;
  } ld_row_t;

  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc, stb, we, ack, soc_int;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, d;
  meas_t       meas = '0;
  results_t    res = '0;
  engine_t     eng;
  row_t        rows [8];
  ld_row_t     lds [15];
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          cyc_cnt = 0;
  int          n;

  always #25 sys_clk = ~sys_clk;

  // ce held high: freezing is not a documented behaviour
  charge_state_gauge #(.PULSE_CYC(PULSE)) u_charge_state_gauge (
    .sys_clk(sys_clk), .rst(rst), .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .meas_i(meas), .res_i(res), .soc_int_o(soc_int), .eng_o(eng));

  wb_host_model u_wb_host_model (
    .sys_clk(sys_clk), .ack(ack), .rdat(rdat), .cyc(cyc), .stb(stb), .we(we),
    .adr(adr), .sel(sel), .wdat(wdat));

  task automatic give_verdict();
    if (error_cnt == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one-cycle strobes, back to back is allowed
  task automatic send_meas(input logic [15:0] v, input logic signed [15:0] c);
    @(posedge sys_clk);
    meas <= '{stb: 1'b1, volt_mv: v, ocv_mv: 16'h0E10, cur_ma: c, temp: 16'h0BB8};
    @(posedge sys_clk);
    meas.stb <= 1'b0;
  endtask

  task automatic send_res(input logic [15:0] r);
    @(posedge sys_clk);
    res <= '{stb: 1'b1, rem: r, full: 16'h03E8, nom: r, favail: 16'h03E8};
    @(posedge sys_clk);
    res.stb <= 1'b0;
  endtask

  // counts edges with the pin at its active level
  task automatic count_int(input logic p, output int cnt);
    cnt = 0;
    repeat (20)
    begin
      @(posedge sys_clk);
      if (soc_int === p)
        cnt++;
    end
  endtask

  // hang guard
  always @(posedge sys_clk)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == LIMIT)
    begin
      error_cnt++;
      give_verdict();
    end
  end

  initial
  begin
    // volt, current, remaining, expected status {chg,dsg,sd,low,mode}
    rows = '{'{16'h0E74, 16'sh0000, 16'h01F4, 5'h00}, '{16'h0E74, -16'sh003D, 16'h0097, 5'h08},
             '{16'h0E74, -16'sh003C, 16'h0096, 5'h00}, '{16'h0E74, 16'sh004C, 16'h0095, 5'h12},
             '{16'h0E74, 16'sh004B, 16'h0096, 5'h02}, '{16'h0C4D, 16'sh0000, 16'h0097, 5'h04},
             '{16'h0D48, 16'sh0000, 16'h0097, 5'h04}, '{16'h0D49, 16'sh0000, 16'h0097, 5'h00}};
    // control word, expected load value
    lds = '{'{8'h00, 16'h003D}, '{8'h02, 16'h003D}, '{8'h04, 16'h0005}, '{8'h06, 16'h0001},
            '{8'h0E, 16'h003D}, '{8'h01, 16'h0016}, '{8'h03, 16'h0016}, '{8'h05, 16'h0001},
            '{8'h07, 16'h0000}, '{8'h08, 16'h00C8}, '{8'h0A, 16'h0037}, '{8'h0C, 16'h007B},
            '{8'h09, 16'h004A}, '{8'h0B, 16'h0037}, '{8'h0D, 16'h004D}};
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk("idle pin", 32'h1, {31'h0, soc_int});
    u_wb_host_model.rd(ADDR_CTRL, d);
    chk("ctrl reset", 32'h2, d);
    // thresholds left at defaults, above noise
    for (int i = 0; i < NCFG; i++)
    begin
      u_wb_host_model.rd(8'(CFG_BASE + 8'(4 * i)), d);
      chk("cfg reset", {16'h0000, CFG_RST[i]}, d);
    end
    u_wb_host_model.rd(8'hFC, d);
    chk("unmapped", 32'h0, d);
    // flag table with hysteresis and threshold boundaries
    for (int i = 0; i < 8; i++)
    begin
      send_meas(rows[i].volt, rows[i].cur);
      send_res(rows[i].rem);
      u_wb_host_model.rd(ADDR_STATUS, d);
      chk("status", {27'h0, rows[i].st}, d);
    end
    u_wb_host_model.wr(8'h24, 32'h37);
    u_wb_host_model.wr(8'h28, 32'h7B);
    u_wb_host_model.wr(8'h2C, 32'h4D);
    u_wb_host_model.wr(8'h30, 32'h11);
    u_wb_host_model.wr(8'h34, 32'h22);
    // load model selection in both modes
    for (int i = 0; i < 15; i++)
    begin
      u_wb_host_model.wr(ADDR_CTRL, {24'h0, lds[i].ctrl});
      u_wb_host_model.rd(ADDR_LOAD, d);
      chk("load reg", {16'h0, lds[i].val}, d);
      chk("load out", {16'h0, lds[i].val}, {16'h0, eng.load_value});
      chk("load mode", {31'h0, lds[i].ctrl[0]}, {31'h0, eng.load_mode});
      u_wb_host_model.rd(ADDR_STATUS, d);
      chk("mode mirror", {31'h0, lds[i].ctrl[0]}, d);
    end
    chk("reserve", 32'h00110022, {eng.rsv_chg, eng.rsv_en});
    u_wb_host_model.rd(ADDR_NOM, d);
    chk("nominal", 32'h97, d);
    u_wb_host_model.rd(ADDR_FULL, d);
    chk("full", 32'h3E8, d);
    send_meas(16'h0DAC, -16'sh0064);
    u_wb_host_model.rd(ADDR_IRDROP, d);
    chk("ir drop", 32'h64, d);
    chk("dsg out", 32'h1, {31'h0, eng.dsg});
    // active-high pin: pulse on set and on clear of shutdown
    u_wb_host_model.wr(ADDR_CTRL, 32'h12);
    @(posedge sys_clk);
    chk("idle pol1", 32'h0, {31'h0, soc_int});
    send_meas(16'h0C1C, 16'sh0000);
    count_int(1'b1, n);
    chk("set pulse", {16'h0, PULSE}, 32'(n));
    send_meas(16'h0DAC, 16'sh0000);
    count_int(1'b1, n);
    chk("clear pulse", {16'h0, PULSE}, 32'(n));
    // second reset in mid-run
    u_wb_host_model.wr(ADDR_CTRL, 32'h1D);
    @(posedge sys_clk);
    rst <= 1'b1;
    @(posedge sys_clk);
    rst <= 1'b0;
    u_wb_host_model.rd(ADDR_CTRL, d);
    chk("ctrl rereset", 32'h2, d);
    chk("pin rereset", 32'h1, {31'h0, soc_int});
    give_verdict();
  end
endmodule
`default_nettype wire
